/* logic/hppc_top.sv */
// host port, interrupt queue and serial pcm pins
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// fifo
// ----------------------------------------
module hppc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic [AW:0]      next_wrPtr;
    logic [AW:0]      next_rdPtr;
    logic             doWrite;
    logic             doRead;

    assign outValid = (wrPtr != rdPtr);
    assign inReady  = (wrPtr[AW-1:0] != rdPtr[AW-1:0]) || (wrPtr[AW] == rdPtr[AW]);
    assign outData  = mem[rdPtr[AW-1:0]];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always_comb begin
        next_wrPtr = wrPtr + (AW+1)'(doWrite);
        next_rdPtr = rdPtr + (AW+1)'(doRead);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
    end

    // storage has no reset: contents are only read behind the pointers
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module hppc_top (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire hppc_pkg::hppc_host_t hostReq,
    input  wire logic [7:0]         hostDataIn,
    output logic      [7:0]         hostDataOut,
    output logic                    hostDataOe,
    output logic                    transferAckOut,
    output logic                    transferAckOe,
    output logic                    irqOut,
    output logic                    irqOe,
    input  wire logic               irqEntryValid,
    output logic                    irqEntryReady,
    input  wire logic [7:0]         irqEntry,
    input  wire logic               outputDriveEnable,
    input  wire logic               serialBitClock,
    input  wire logic               framePulseIn,
    input  wire logic               rinData,
    input  wire logic               sinData,
    output logic                    soutData,
    output logic                    soutOe,
    output logic                    routData,
    output logic                    routOe,
    input  wire logic [7:0]         soutByte,
    input  wire logic [7:0]         routByte,
    output logic      [4:0]         txChannel,
    output hppc_pkg::hppc_rx_t      rxWord,
    output logic                    rxValid,
    output logic                    gciMode
);
    // ----------------------------------------
    // host port
    // ----------------------------------------
    hppc_pkg::hppc_state_t state;
    hppc_pkg::hppc_state_t next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] next_hostDataOut;
    logic       access;
    logic       isRead;
    logic       fifoValid;
    logic       fifoPop;
    logic [7:0] fifoData;
    logic       next_irqOe;
    logic       fifoSingle;
    logic [5:0] fifoCount;
    logic [5:0] next_fifoCount;

    assign access = !hostReq.chipSelectN && !hostReq.dataStrobeN;
    assign isRead = hostReq.readNotWrite;
    assign fifoPop = (state == hppc_pkg::ST_SETUP) && access && isRead
                     && (hostReq.hostAddressBus == hppc_pkg::IRQ_FIFO_ADDR);
    assign hostDataOe = (state != hppc_pkg::ST_IDLE) && access && isRead;
    assign transferAckOut = 1'b0;
    assign transferAckOe = (state == hppc_pkg::ST_ACK) && access;
    assign irqOut = 1'b0;

    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_hostDataOut = hostDataOut;
        unique case (state)
            hppc_pkg::ST_IDLE: begin
                if (access) begin
                    next_state = hppc_pkg::ST_SETUP;
                end
            end
            hppc_pkg::ST_SETUP: begin
                if (!access) begin
                    next_state = hppc_pkg::ST_IDLE;
                end else begin
                    next_state = hppc_pkg::ST_ACK;
                    if (isRead) begin
                        unique case (hostReq.hostAddressBus)
                            hppc_pkg::CTRL_ADDR: next_hostDataOut = ctrl;
                            hppc_pkg::IRQ_FIFO_ADDR:
                                next_hostDataOut = fifoValid ? fifoData : 8'h00;
                            hppc_pkg::STATUS_ADDR:
                                next_hostDataOut = {7'h00, gciMode};
                            default: next_hostDataOut = 8'h00;
                        endcase
                    end else if (hostReq.hostAddressBus == hppc_pkg::CTRL_ADDR) begin
                        next_ctrl = hostDataIn;
                    end
                end
            end
            hppc_pkg::ST_ACK: begin
                if (!access) begin
                    next_state = hppc_pkg::ST_IDLE;
                end
            end
            default: next_state = hppc_pkg::ST_IDLE;
        endcase
        next_irqOe = fifoValid && !(fifoPop && !irqEntryValid && fifoSingle);
    end

    assign fifoSingle = (fifoCount == 6'h01);

    // a read of the empty queue must not wrap the count
    always_comb begin
        next_fifoCount = fifoCount + 6'(irqEntryValid && irqEntryReady)
                         - 6'(fifoPop && fifoValid);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= hppc_pkg::ST_IDLE;
            ctrl <= hppc_pkg::CTRL_RESET;
            hostDataOut <= 8'h00;
            irqOe <= 1'b0;
            fifoCount <= 6'h00;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            hostDataOut <= next_hostDataOut;
            irqOe <= next_irqOe;
            fifoCount <= next_fifoCount;
        end
    end

    // back-pressure: a full queue stalls the event source
    hppc_fifo #(
        .WIDTH (8),
        .DEPTH (hppc_pkg::IRQ_FIFO_DEPTH)
    ) u_irqFifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (irqEntryValid),
        .inReady  (irqEntryReady),
        .inData   (irqEntry),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // ----------------------------------------
    // serial pcm
    // ----------------------------------------
    logic       sclkLast;
    logic       fpLast;
    logic [3:0] fpStable;
    logic [8:0] bitCnt;
    logic [7:0] rinShift;
    logic [7:0] sinShift;
    logic [7:0] soutHold;
    logic [7:0] routHold;
    logic       sclkRise;
    logic       sclkFall;
    logic       frameStart;
    logic       driveOn;
    logic [3:0] next_fpStable;
    logic       next_gciMode;
    logic [8:0] next_bitCnt;
    logic [7:0] next_rinShift;
    logic [7:0] next_sinShift;
    logic [7:0] next_soutHold;
    logic [7:0] next_routHold;
    logic       next_soutData;
    logic       next_routData;
    hppc_pkg::hppc_rx_t next_rxWord;
    logic       next_rxValid;

    assign sclkRise = serialBitClock && !sclkLast;
    assign sclkFall = !serialBitClock && sclkLast;
    // a level change after a long steady stretch marks the active edge
    assign frameStart = sclkFall && (framePulseIn != fpLast) && (fpStable == hppc_pkg::IDLE_MIN);
    assign driveOn = outputDriveEnable && ctrl[hppc_pkg::DRIVE_EN_BIT];
    assign soutOe = driveOn;
    assign routOe = driveOn;
    assign txChannel = bitCnt[8:4];

    always_comb begin
        next_fpStable = fpStable;
        next_gciMode = gciMode;
        next_bitCnt = bitCnt;
        next_rinShift = rinShift;
        next_sinShift = sinShift;
        next_soutHold = soutHold;
        next_routHold = routHold;
        next_soutData = soutData;
        next_routData = routData;
        next_rxWord = rxWord;
        next_rxValid = 1'b0;
        if (sclkFall) begin
            if (framePulseIn != fpLast) begin
                next_fpStable = 4'h0;
            end else if (fpStable != hppc_pkg::IDLE_MIN) begin
                next_fpStable = fpStable + 4'h1;
            end
            if (frameStart) begin
                next_gciMode = framePulseIn;
                next_bitCnt = 9'h000;
            end else begin
                next_bitCnt = bitCnt + 9'h001;
            end
            // two serial clocks per bit, eight bits per channel
            if (next_bitCnt[0] == 1'b0) begin
                if (next_bitCnt[3:0] == 4'h0) begin
                    next_soutHold = soutByte;
                    next_routHold = routByte;
                end
                next_soutData = (next_bitCnt[3:0] == 4'h0) ? soutByte[7]
                                : soutHold[3'h7 - next_bitCnt[3:1]];
                next_routData = (next_bitCnt[3:0] == 4'h0) ? routByte[7]
                                : routHold[3'h7 - next_bitCnt[3:1]];
            end
        end
        // sample in the second half of each bit cell
        if (sclkRise && bitCnt[0]) begin
            next_rinShift = {rinShift[6:0], rinData};
            next_sinShift = {sinShift[6:0], sinData};
            if (bitCnt[3:0] == hppc_pkg::LAST_SLOT_CNT) begin
                next_rxWord.channel = bitCnt[8:4];
                next_rxWord.rinByte = {rinShift[6:0], rinData};
                next_rxWord.sinByte = {sinShift[6:0], sinData};
                next_rxValid = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclkLast <= 1'b0;
            fpLast <= 1'b0;
            fpStable <= 4'h0;
            gciMode <= 1'b0;
            bitCnt <= 9'h000;
            rinShift <= 8'h00;
            sinShift <= 8'h00;
            soutHold <= 8'h00;
            routHold <= 8'h00;
            soutData <= 1'b1;
            routData <= 1'b1;
            rxWord <= '0;
            rxValid <= 1'b0;
        end else begin
            sclkLast <= serialBitClock;
            fpLast <= sclkFall ? framePulseIn : fpLast;
            fpStable <= next_fpStable;
            gciMode <= next_gciMode;
            bitCnt <= next_bitCnt;
            rinShift <= next_rinShift;
            sinShift <= next_sinShift;
            soutHold <= next_soutHold;
            routHold <= next_routHold;
            soutData <= next_soutData;
            routData <= next_routData;
            rxWord <= next_rxWord;
            rxValid <= next_rxValid;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_accessOpen;
        (state == hppc_pkg::ST_IDLE) && access;
    endsequence
    sequence s_ackHeld;
        access [*2];
    endsequence
    property p_irqRaise;
        @(posedge mclk) disable iff (rst) (fifoValid && !fifoPop) |=> irqOe;
    endproperty
    a_irqRaise: assert property (p_irqRaise) else $error("irq not raised");
    property p_irqRelease;
        @(posedge mclk) disable iff (rst) (!fifoValid && !irqEntryValid) |=> !irqOe;
    endproperty
    a_irqRelease: assert property (p_irqRelease) else $error("irq held");
    property p_noAccess;
        @(posedge mclk) disable iff (rst)
            ((state == hppc_pkg::ST_IDLE) && !access) |=> (state == hppc_pkg::ST_IDLE);
    endproperty
    a_noAccess: assert property (p_noAccess) else $error("access w/o strobe");
    property p_readDrive;
        @(posedge mclk) disable iff (rst) hostDataOe |-> (isRead && access);
    endproperty
    a_readDrive: assert property (p_readDrive) else $error("bus driven on write");
    property p_ackAfter;
        @(posedge mclk) disable iff (rst) s_accessOpen ##1 s_ackHeld |-> transferAckOe;
    endproperty
    a_ackAfter: assert property (p_ackAfter) else $error("no ack");
    property p_ackRelease;
        @(posedge mclk) disable iff (rst) !access |-> !transferAckOe;
    endproperty
    a_ackRelease: assert property (p_ackRelease) else $error("ack stuck");
    property p_driveOn;
        @(posedge mclk) disable iff (rst)
            ((state == hppc_pkg::ST_SETUP) && access && !isRead
             && (hostReq.hostAddressBus == hppc_pkg::CTRL_ADDR) && hostDataIn[6])
            ##1 outputDriveEnable |-> (soutOe && routOe);
    endproperty
    a_driveOn: assert property (p_driveOn) else $error("outputs not enabled");
    property p_driveOff;
        @(posedge mclk) disable iff (rst) !outputDriveEnable |-> (!soutOe && !routOe);
    endproperty
    a_driveOff: assert property (p_driveOff) else $error("outputs driven");
    property p_frameReset;
        @(posedge mclk) disable iff (rst) frameStart |=> (bitCnt == 9'h000);
    endproperty
    a_frameReset: assert property (p_frameReset) else $error("frame count");
    property p_rxChannel;
        @(posedge mclk) disable iff (rst) rxValid |-> (rxWord.channel == $past(bitCnt[8:4]));
    endproperty
    a_rxChannel: assert property (p_rxChannel) else $error("rx channel");
    property p_format;
        @(posedge mclk) disable iff (rst) frameStart |=> (gciMode == $past(framePulseIn));
    endproperty
    a_format: assert property (p_format) else $error("format detect");
endmodule
`default_nettype wire

/* logic/hppc_pkg.sv */
// constants and carrier types for the host port and pcm pin control
`default_nettype none
package hppc_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam logic [10:0] CTRL_ADDR = 11'h400;
    localparam logic [10:0] IRQ_FIFO_ADDR = 11'h401;
    localparam logic [10:0] STATUS_ADDR = 11'h402;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int DRIVE_EN_BIT = 6;
    localparam int IRQ_FIFO_DEPTH = 32;
    localparam int CHANNELS = 32;
    localparam int SERIAL_CLK_KHZ = 4096;
    localparam int BIT_RATE_KBPS = 2048;
    localparam int CLK_PER_BIT = SERIAL_CLK_KHZ / BIT_RATE_KBPS;
    localparam int FRAME_CNT_W = 9;
    localparam logic [3:0] IDLE_MIN = 4'hF;
    localparam logic [3:0] LAST_SLOT_CNT = 4'hF;

    typedef struct packed {
        logic        chipSelectN;
        logic        dataStrobeN;
        logic        readNotWrite;
        logic [10:0] hostAddressBus;
    } hppc_host_t;

    typedef struct packed {
        logic [4:0] channel;
        logic [7:0] rinByte;
        logic [7:0] sinByte;
    } hppc_rx_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACK   = 3'b100
    } hppc_state_t;
endpackage
`default_nettype wire

/* sim/hppc_partner.sv */
// backplane model: serial clock, frame pulse, pcm inputs, output capture
`timescale 1ns/1ps
`default_nettype none
module hppc_partner (
    input  wire logic       polHigh,
    input  wire logic [7:0] rinSrc,
    input  wire logic [7:0] sinSrc,
    input  wire logic       soutData,
    input  wire logic       soutOe,
    input  wire logic       routData,
    input  wire logic       routOe,
    output logic            serialBitClock,
    output logic            framePulseIn,
    output logic            rinData,
    output logic            sinData,
    output logic      [8:0] pCnt,
    output logic            repValid,
    output logic      [7:0] soutGot,
    output logic      [7:0] routGot
);
    logic [8:0] nCnt;
    logic [7:0] rSh, sSh, soSh, roSh;
    logic       soW, roW;
    assign repValid = serialBitClock & (pCnt[3:0] == 4'hF);
    // ----------------------------------------
    // clock and framing
    // ----------------------------------------
    initial begin
        pCnt = 9'h100;
        framePulseIn = 1'b1;
        rinData = 1'b1;
        sinData = 1'b1;
        rSh = 8'h00;
        sSh = 8'h00;
        soW = 1'b0;
        roW = 1'b0;
        serialBitClock = 1'b1;
        // odd offset keeps every edge clear of mclk; rate a hair fast
        #7;
        forever #122 serialBitClock = ~serialBitClock;
    end
    always @(negedge serialBitClock) begin
        nCnt = pCnt + 9'h001;
        pCnt <= nCnt;
        framePulseIn <= (nCnt == 9'h000) ? polHigh : ~polHigh;
        // loaded at channel start, one byte per 16 falls
        if (nCnt[3:0] == 4'h0) begin
            rSh = rinSrc;
            sSh = sinSrc;
        end
        if (!nCnt[0]) begin
            rinData <= rSh[3'h7 - nCnt[3:1]];
            sinData <= sSh[3'h7 - nCnt[3:1]];
        end
    end
    // ----------------------------------------
    // output capture
    // ----------------------------------------
    always @(posedge serialBitClock) begin
        // a floating line toggles so stale bits never match
        soW = soutOe ? soutData : ~soW;
        roW = routOe ? routData : ~roW;
        if (pCnt[0]) begin
            soSh = {soSh[6:0], soW};
            roSh = {roSh[6:0], roW};
            if (pCnt[3:0] == 4'hF) begin
                soutGot <= soSh;
                routGot <= roSh;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the host port, interrupt queue and pcm pins
`timescale 1ns/1ps
`default_nettype none
module tb;
    hppc_pkg::hppc_host_t hostReq;
    hppc_pkg::hppc_rx_t   rxWord;
    logic [7:0]  hostDataIn, hostDataOut, benchData, lastBus, irqEntry, soutByte, routByte;
    logic [7:0]  soutGot, routGot, rd, e, sB, rB;
    logic        mclk, rst, benchOe, hostDataOe, transferAckOut, transferAckOe, irqOut, irqOe;
    logic        irqEntryValid, irqEntryReady, outputDriveEnable, serialBitClock, framePulseIn;
    logic        rinData, sinData, soutData, soutOe, routData, routOe, rxValid, gciMode;
    logic        polHigh, repValid, prevRep, chkOn, ctrlBit;
    logic [4:0]  txChannel, lastSet, nxtChan;
    logic [8:0]  pCnt, prevCnt;
    logic [31:0] rng;
    logic [15:0] txQ[$];
    logic [7:0]  irqQ[$];
    int          err_total, total_checks, frameCnt, n;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd8();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    function automatic logic [7:0] rinF(input logic [4:0] c);
        return {c, 3'h5} ^ 8'h3C;
    endfunction
    function automatic logic [7:0] sinF(input logic [4:0] c);
        return ~{c[2:0], c};
    endfunction
    task automatic cmp1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic hostAccess(input logic rw, input logic [10:0] a, input logic [7:0] wd,
                              output logic [7:0] rdat);
        int k;
        @(posedge mclk);
        hostReq <= '{chipSelectN: 1'b0, dataStrobeN: 1'b0, readNotWrite: rw,
                     hostAddressBus: a};
        benchOe <= ~rw;
        benchData <= wd;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (transferAckOe !== 1'b1 && k < 20);
        cmp8(8'(k), 8'h03);
        cmp1(hostDataOe, rw);
        rdat = hostDataOut;
        @(posedge mclk);
        hostReq.chipSelectN <= 1'b1;
        hostReq.dataStrobeN <= 1'b1;
        benchOe <= 1'b0;
        @(negedge mclk);
        cmp1(transferAckOe, 1'b0);
    endtask
    task automatic waitFrames(input int k);
        int t;
        int w;
        t = frameCnt + k;
        w = 0;
        while (frameCnt < t && w < 3300 * k) begin
            @(posedge mclk);
            w++;
        end
        cmp1(frameCnt >= t, 1'b1);
    endtask
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    // undriven data bus shows the inverse of its last level
    assign hostDataIn = hostDataOe ? hostDataOut : (benchOe ? benchData : ~lastBus);
    assign nxtChan = pCnt[8:4] + 5'h01;
    hppc_top hppc_top_i (.mclk(mclk), .rst(rst), .hostReq(hostReq), .hostDataIn(hostDataIn),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .transferAckOut(transferAckOut),
        .transferAckOe(transferAckOe), .irqOut(irqOut), .irqOe(irqOe),
        .irqEntryValid(irqEntryValid), .irqEntryReady(irqEntryReady), .irqEntry(irqEntry),
        .outputDriveEnable(outputDriveEnable), .serialBitClock(serialBitClock),
        .framePulseIn(framePulseIn), .rinData(rinData), .sinData(sinData),
        .soutData(soutData), .soutOe(soutOe), .routData(routData), .routOe(routOe),
        .soutByte(soutByte), .routByte(routByte), .txChannel(txChannel), .rxWord(rxWord),
        .rxValid(rxValid), .gciMode(gciMode));
    hppc_partner hppc_partner_i (.polHigh(polHigh), .rinSrc(rinF(nxtChan)),
        .sinSrc(sinF(nxtChan)), .soutData(soutData), .soutOe(soutOe), .routData(routData),
        .routOe(routOe), .serialBitClock(serialBitClock), .framePulseIn(framePulseIn),
        .rinData(rinData), .sinData(sinData), .pCnt(pCnt), .repValid(repValid),
        .soutGot(soutGot), .routGot(routGot));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #2500000;
        err_total++;
        print_verdict();
    end
    // ----------------------------------------
    // stream monitor and transmit stimulus
    // ----------------------------------------
    always @(posedge mclk) begin
        lastBus <= hostDataIn;
        prevRep <= repValid;
        prevCnt <= pCnt;
        if (pCnt == 9'h000 && prevCnt != 9'h000) begin
            frameCnt <= frameCnt + 1;
            if (chkOn) outputDriveEnable <= (rnd8() > 8'h50);
        end
        if (!chkOn) begin
            txQ.delete();
        end else begin
            if (rxValid === 1'b1) begin
                cmp8({3'h0, rxWord.channel}, {3'h0, pCnt[8:4]});
                cmp8(rxWord.rinByte, rinF(pCnt[8:4]));
                cmp8(rxWord.sinByte, sinF(pCnt[8:4]));
            end
            if (repValid && !prevRep) begin
                cmp8({3'h0, txChannel}, {3'h0, pCnt[8:4]});
                cmp1(soutOe, outputDriveEnable & ctrlBit);
                cmp1(routOe, outputDriveEnable & ctrlBit);
                if (txQ.size() == 2) begin
                    if (outputDriveEnable & ctrlBit) begin
                        cmp8(soutGot, txQ[0][15:8]);
                        cmp8(routGot, txQ[0][7:0]);
                    end
                    void'(txQ.pop_front());
                end
            end
            // new bytes mid-channel, well clear of the load at channel start
            if (pCnt[3:0] == 4'h8 && pCnt[8:4] != lastSet) begin
                lastSet <= pCnt[8:4];
                sB = rnd8();
                rB = rnd8();
                soutByte <= sB;
                routByte <= rB;
                txQ.push_back({sB, rB});
            end
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        hostReq = '{chipSelectN: 1'b1, dataStrobeN: 1'b1, readNotWrite: 1'b1,
                    hostAddressBus: 11'h000};
        {benchOe, irqEntryValid, outputDriveEnable, polHigh, chkOn, ctrlBit} = 6'h00;
        {benchData, lastBus, irqEntry, soutByte, routByte} = 40'h0;
        {err_total, total_checks, frameCnt} = 0;
        lastSet = 5'h00;
        rng = 32'h17;
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        cmp1(irqOe, 1'b0);
        cmp1(transferAckOut, 1'b0);
        cmp1(soutOe, 1'b0);
        cmp1(irqOut, 1'b0);
        hostAccess(1'b1, hppc_pkg::CTRL_ADDR, 8'h00, rd);
        cmp8(rd, hppc_pkg::CTRL_RESET);
        for (int i = 0; i < 4; i++) begin
            hostAccess(1'b0, hppc_pkg::CTRL_ADDR, {1'b0, i[1], 6'h15}, rd);
            @(posedge mclk);
            outputDriveEnable <= i[0];
            @(negedge mclk);
            cmp1(soutOe, i[0] & i[1]);
            cmp1(routOe, i[0] & i[1]);
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            hostReq <= '{chipSelectN: i[0], dataStrobeN: ~i[0], readNotWrite: 1'b0,
                         hostAddressBus: hppc_pkg::CTRL_ADDR};
            benchOe <= 1'b1;
            repeat (4) @(negedge mclk);
            cmp1(transferAckOe, 1'b0);
            @(posedge mclk);
            hostReq <= '{chipSelectN: 1'b1, dataStrobeN: 1'b1, readNotWrite: 1'b1,
                         hostAddressBus: 11'h000};
            benchOe <= 1'b0;
        end
        hostAccess(1'b0, {1'b0, rnd8(), 2'h1}, 8'hFF, rd);
        hostAccess(1'b1, {1'b0, rnd8(), 2'h2}, 8'h00, rd);
        cmp8(rd, 8'h00);
        hostAccess(1'b1, hppc_pkg::CTRL_ADDR, 8'h00, rd);
        cmp8(rd, 8'h55);
        n = 0;
        while (n < 40) begin
            @(posedge mclk);
            e = rnd8();
            irqEntryValid <= 1'b1;
            irqEntry <= e;
            @(negedge mclk);
            if (n == 1) cmp1(irqOe, 1'b1);
            if (irqEntryReady !== 1'b1) break;
            @(posedge mclk);
            irqEntryValid <= 1'b0;
            irqQ.push_back(e);
            n++;
        end
        @(posedge mclk);
        irqEntryValid <= 1'b0;
        cmp8(8'(n), 8'(hppc_pkg::IRQ_FIFO_DEPTH));
        cmp1(irqEntryReady, 1'b0);
        while (irqQ.size() > 0) begin
            cmp1(irqOe, 1'b1);
            hostAccess(1'b1, hppc_pkg::IRQ_FIFO_ADDR, 8'h00, rd);
            cmp8(rd, irqQ.pop_front());
        end
        cmp1(irqOe, 1'b0);
        hostAccess(1'b1, hppc_pkg::IRQ_FIFO_ADDR, 8'h00, rd);
        cmp8(rd, 8'h00);
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                // mid-run reset; polarity flips while the design is held
                @(posedge mclk);
                rst <= 1'b1;
                polHigh <= 1'b1;
                repeat (10) @(posedge mclk);
                rst <= 1'b0;
                hostAccess(1'b1, hppc_pkg::CTRL_ADDR, 8'h00, rd);
                cmp8(rd, hppc_pkg::CTRL_RESET);
            end
            hostAccess(1'b0, hppc_pkg::CTRL_ADDR, 8'h40, rd);
            ctrlBit = 1'b1;
            @(posedge mclk);
            outputDriveEnable <= 1'b1;
            waitFrames(2);
            chkOn = 1'b1;
            waitFrames(3);
            chkOn = 1'b0;
            hostAccess(1'b1, hppc_pkg::STATUS_ADDR, 8'h00, rd);
            cmp8(rd & 8'h01, {7'h00, polHigh});
            cmp1(gciMode, polHigh);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
